// >>> verilog/dism_top.sv
// dual interrupt status and mask bank with register port and two outputs
`timescale 1ns/1ps

// Operation
// - status flags stay set until a one is written to them; zeros do nothing
// - every first-output flag has a mask bit; 0 lets it through, 1 blocks
// - boot-complete mask, and bit 8 of second-output mask register 4, reset unmasked; every other mask resets masked
// - control bit 0, reset 0, set to 1 silences the first output
// - always-on status has its own mask register, reset all ones
// - gpin5 falling sets bit 5, rising sets bit 4
// - jack detect falling sets bit 3, rising sets bit 2
// - speaker shutdown flag bit 14 sets on rising edge only
// - right and left short flags, bits 13 and 12, set on both edges
// - gpio 1 to 4 flags, bits 0 to 3, set on both edges
// - speaker off-done bits 15,14 and on-done bits 13,12 set on rising edge
// - thermal warning bit 15 and thermal bit 14 set on both edges
// - headphone sense flag bit 13 sets on rising edge
// - accessory sense flag bit 12 sets on each detection event
// - write sequencer finished flag bit 11 sets on rising edge
// - dynamics signal bit 9, rate converter locks bits 8 and 7: both edges
// - clock too slow bit 6 and too fast bit 5 set on rising edge
// - loop1 clock good flag bit 0 sets on both edges
// - second output has six per-flag mask registers, 0 unmask, 1 mask
// - second output control bit 0, reset 0, set to 1 silences it
module dism_top (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    input  wire logic        i_gpin5,
    input  wire logic        i_jack_detect,
    input  wire logic        i_mic_clamp,
    input  wire logic        i_boot_done,
    input  wire logic        i_loop1_clock_good,
    input  wire logic        i_speaker_shutdown,
    input  wire logic        i_right_speaker_short,
    input  wire logic        i_left_speaker_short,
    input  wire logic [3:0]  i_gpio,
    input  wire logic        i_right_speaker_off_done,
    input  wire logic        i_left_speaker_off_done,
    input  wire logic        i_right_speaker_on_done,
    input  wire logic        i_left_speaker_on_done,
    input  wire logic        i_speaker_thermal_warning,
    input  wire logic        i_speaker_thermal,
    input  wire logic        i_headphone_sense_done,
    input  wire logic        i_accessory_sense_event,
    input  wire logic        i_write_sequencer_done,
    input  wire logic        i_dynamics_signal,
    input  wire logic [1:0]  i_rate_converter_lock,
    input  wire logic        i_clock_too_slow,
    input  wire logic        i_clock_too_fast,
    output logic             o_irq1,
    output logic             o_irq2
);

    ////////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        hit = (addr == off);
    endfunction

    // index of a mask register inside a six-register bank, valid flag on top
    function automatic logic [3:0] mask_slot(input logic [15:0] addr,
                                             input logic [15:0] base);
        logic [15:0] diff;
        diff = addr - base;
        if (addr >= base && diff < 16'(dism_pkg::MASK_REGS)) begin
            mask_slot = {1'b1, diff[2:0]};
        end else begin
            mask_slot = 4'h0;
        end
    endfunction

    function automatic logic [15:0] w1c(input logic sel, input logic [15:0] wdata);
        w1c = sel ? wdata : 16'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control state

    logic [15:0] irq1_mask [dism_pkg::MASK_REGS];
    logic [15:0] irq2_mask [dism_pkg::MASK_REGS];
    logic [15:0] irq1_always_on_mask;
    logic        first_output_mask;
    logic        second_output_mask;

    wire         wr_hit_s5    = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ1_STATUS5);
    wire         wr_hit_s6    = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ1_SPK_FAULT);
    wire         wr_hit_aod   = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ1_AOD_STATUS);
    wire         wr_hit_g1    = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ2_GPIO);
    wire         wr_hit_g2    = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ2_SPK_SEQ);
    wire         wr_hit_g3    = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ2_SYS_EVENT);
    wire         wr_hit_ctl1  = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ1_OUTPUT_CTRL);
    wire         wr_hit_ctl2  = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ2_OUTPUT_CTRL);
    wire         wr_hit_aodm  = i_reg_wr && hit(i_reg_addr, dism_pkg::OFF_IRQ1_AOD_MASK);
    wire [3:0]   slot1        = mask_slot(i_reg_addr, dism_pkg::OFF_IRQ1_MASK_BASE);
    wire [3:0]   slot2        = mask_slot(i_reg_addr, dism_pkg::OFF_IRQ2_MASK_BASE);

    ////////////////////////////////////////////////////////////////////////
    // first output flag registers

    dism_flag_if #(.W(dism_pkg::REG_W)) s5_if ();
    dism_flag_if #(.W(dism_pkg::REG_W)) s6_if ();
    dism_flag_if #(.W(dism_pkg::REG_W)) aod_if ();

    assign s5_if.src = {7'h00, i_boot_done, 7'h00, i_loop1_clock_good};
    assign s5_if.clr = w1c(wr_hit_s5, i_reg_wdata);

    assign s6_if.src = {1'b0, i_speaker_shutdown, i_right_speaker_short,
                        i_left_speaker_short, 12'h000};
    assign s6_if.clr = w1c(wr_hit_s6, i_reg_wdata);

    // each gpin5, jack and clamp source feeds a falling bit and a rising bit
    assign aod_if.src = {8'h00, i_mic_clamp, i_mic_clamp, i_gpin5, i_gpin5,
                         i_jack_detect, i_jack_detect, 2'b00};
    assign aod_if.clr = w1c(wr_hit_aod, i_reg_wdata);

    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::S5_RISE),
        .FALL  (dism_pkg::S5_FALL),
        .EVENT (dism_pkg::NO_EVENT)
    ) u_irq1_status5 (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (s5_if.bank)
    );

    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::S6_RISE),
        .FALL  (dism_pkg::S6_FALL),
        .EVENT (dism_pkg::NO_EVENT)
    ) u_irq1_speaker_fault (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (s6_if.bank)
    );

    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::AOD_RISE),
        .FALL  (dism_pkg::AOD_FALL),
        .EVENT (dism_pkg::NO_EVENT)
    ) u_irq1_always_on (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (aod_if.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // second output flag registers, fed by their own sources

    dism_flag_if #(.W(dism_pkg::REG_W)) g1_if ();
    dism_flag_if #(.W(dism_pkg::REG_W)) g2_if ();
    dism_flag_if #(.W(dism_pkg::REG_W)) g3_if ();

    assign g1_if.src = {12'h000, i_gpio};
    assign g1_if.clr = w1c(wr_hit_g1, i_reg_wdata);

    assign g2_if.src = {i_right_speaker_off_done, i_left_speaker_off_done,
                        i_right_speaker_on_done, i_left_speaker_on_done,
                        12'h000};
    assign g2_if.clr = w1c(wr_hit_g2, i_reg_wdata);

    assign g3_if.src = {i_speaker_thermal_warning, i_speaker_thermal,
                        i_headphone_sense_done, i_accessory_sense_event,
                        i_write_sequencer_done, 1'b0, i_dynamics_signal,
                        i_rate_converter_lock[1], i_rate_converter_lock[0],
                        i_clock_too_slow, i_clock_too_fast, 5'h00};
    assign g3_if.clr = w1c(wr_hit_g3, i_reg_wdata);

    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::G1_RISE),
        .FALL  (dism_pkg::G1_FALL),
        .EVENT (dism_pkg::NO_EVENT)
    ) u_irq2_gpio (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (g1_if.bank)
    );

    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::G2_RISE),
        .FALL  (dism_pkg::G2_FALL),
        .EVENT (dism_pkg::NO_EVENT)
    ) u_irq2_speaker_sequence (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (g2_if.bank)
    );

    // bit 12 is level-captured: the detector delivers a pulse per detection
    dism_flag_bank #(
        .W     (dism_pkg::REG_W),
        .RISE  (dism_pkg::G3_RISE),
        .FALL  (dism_pkg::G3_FALL),
        .EVENT (dism_pkg::G3_EVENT)
    ) u_irq2_system_event (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .bus       (g3_if.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // mask and output control registers

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < dism_pkg::MASK_REGS; i++) begin
                irq1_mask[i] <= (i == dism_pkg::STATUS5_MASK_INDEX) ?
                                dism_pkg::MASK_RESET_BOOT_REG :
                                dism_pkg::MASK_RESET_OTHER;
                irq2_mask[i] <= (i == dism_pkg::STATUS5_MASK_INDEX) ?
                                dism_pkg::MASK_RESET_BOOT_REG :
                                dism_pkg::MASK_RESET_OTHER;
            end
        end else if (i_ce && i_reg_wr) begin
            for (int i = 0; i < dism_pkg::MASK_REGS; i++) begin
                if (slot1 == {1'b1, 3'(i)}) begin
                    irq1_mask[i] <= i_reg_wdata;
                end
                if (slot2 == {1'b1, 3'(i)}) begin
                    irq2_mask[i] <= i_reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq1_always_on_mask <= dism_pkg::AOD_MASK_RESET;
            first_output_mask   <= dism_pkg::OUTPUT_MASK_RESET;
            second_output_mask  <= dism_pkg::OUTPUT_MASK_RESET;
        end else if (i_ce) begin
            if (wr_hit_aodm) begin
                irq1_always_on_mask <= i_reg_wdata;
            end
            if (wr_hit_ctl1) begin
                first_output_mask <= i_reg_wdata[dism_pkg::OUTPUT_MASK_BIT];
            end
            if (wr_hit_ctl2) begin
                second_output_mask <= i_reg_wdata[dism_pkg::OUTPUT_MASK_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs

    dism_irq_gate #(
        .N (3 * dism_pkg::REG_W)
    ) u_irq1_gate (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_status   ({aod_if.status, s6_if.status, s5_if.status}),
        .i_mask     ({irq1_always_on_mask,
                      irq1_mask[dism_pkg::STATUS6_MASK_INDEX],
                      irq1_mask[dism_pkg::STATUS5_MASK_INDEX]}),
        .i_out_mask (first_output_mask),
        .o_irq      (o_irq1)
    );

    dism_irq_gate #(
        .N (3 * dism_pkg::REG_W)
    ) u_irq2_gate (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_status   ({g3_if.status, g2_if.status, g1_if.status}),
        .i_mask     ({irq2_mask[dism_pkg::SYS_EVENT_MASK_INDEX],
                      irq2_mask[dism_pkg::SPK_SEQ_MASK_INDEX],
                      irq2_mask[dism_pkg::GPIO_MASK_INDEX]}),
        .i_out_mask (second_output_mask),
        .o_irq      (o_irq2)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read path; unmapped offsets read zero

    wire [15:0] rd_mask1 = slot1[3] ? irq1_mask[slot1[2:0]] : 16'h0000;
    wire [15:0] rd_mask2 = slot2[3] ? irq2_mask[slot2[2:0]] : 16'h0000;
    wire [15:0] next_rdata =
        hit(i_reg_addr, dism_pkg::OFF_IRQ1_STATUS5)     ? s5_if.status  :
        hit(i_reg_addr, dism_pkg::OFF_IRQ1_SPK_FAULT)   ? s6_if.status  :
        hit(i_reg_addr, dism_pkg::OFF_IRQ1_AOD_STATUS)  ? aod_if.status :
        hit(i_reg_addr, dism_pkg::OFF_IRQ2_GPIO)        ? g1_if.status  :
        hit(i_reg_addr, dism_pkg::OFF_IRQ2_SPK_SEQ)     ? g2_if.status  :
        hit(i_reg_addr, dism_pkg::OFF_IRQ2_SYS_EVENT)   ? g3_if.status  :
        hit(i_reg_addr, dism_pkg::OFF_IRQ1_AOD_MASK)    ? irq1_always_on_mask :
        hit(i_reg_addr, dism_pkg::OFF_IRQ1_OUTPUT_CTRL) ? {15'h0000, first_output_mask} :
        hit(i_reg_addr, dism_pkg::OFF_IRQ2_OUTPUT_CTRL) ? {15'h0000, second_output_mask} :
        (rd_mask1 | rd_mask2);

    // read data is registered so it holds steady until the next read
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= dism_pkg::STATUS_RESET;
        end else if (i_ce && i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

endmodule

// >>> include/dism_pkg.sv
// constants for the dual interrupt status and mask bank
package dism_pkg;

    localparam int          REG_W = 16;
    localparam int          MASK_REGS = 6;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] OFF_IRQ1_STATUS5       = 16'h0d04;
    localparam logic [15:0] OFF_IRQ1_SPK_FAULT     = 16'h0d05;
    localparam logic [15:0] OFF_IRQ1_MASK_BASE     = 16'h0d08;
    localparam logic [15:0] OFF_IRQ1_OUTPUT_CTRL   = 16'h0d0f;
    localparam logic [15:0] OFF_IRQ2_GPIO          = 16'h0d10;
    localparam logic [15:0] OFF_IRQ2_SPK_SEQ       = 16'h0d11;
    localparam logic [15:0] OFF_IRQ2_SYS_EVENT     = 16'h0d12;
    localparam logic [15:0] OFF_IRQ2_MASK_BASE     = 16'h0d18;
    localparam logic [15:0] OFF_IRQ2_OUTPUT_CTRL   = 16'h0d1f;
    localparam logic [15:0] OFF_IRQ1_AOD_STATUS    = 16'h0d51;
    localparam logic [15:0] OFF_IRQ1_AOD_MASK      = 16'h0d53;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int          OUTPUT_MASK_BIT        = 0;
    localparam int          BOOT_FLAG_BIT          = 8;
    localparam int          LOOP1_CLOCK_GOOD_BIT   = 0;
    localparam int          STATUS5_MASK_INDEX     = 4;
    localparam int          STATUS6_MASK_INDEX     = 5;
    localparam int          GPIO_MASK_INDEX        = 0;
    localparam int          SPK_SEQ_MASK_INDEX     = 1;
    localparam int          SYS_EVENT_MASK_INDEX   = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] MASK_RESET_BOOT_REG    = 16'hfeff;
    localparam logic [15:0] MASK_RESET_OTHER       = 16'hffff;
    localparam logic [15:0] AOD_MASK_RESET         = 16'hffff;
    localparam logic        OUTPUT_MASK_RESET      = 1'b0;
    localparam logic [15:0] STATUS_RESET           = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // capture type per status bit: rising, falling, or level event
    localparam logic [15:0] S5_RISE  = 16'h0101;
    localparam logic [15:0] S5_FALL  = 16'h0001;
    localparam logic [15:0] S6_RISE  = 16'h7000;
    localparam logic [15:0] S6_FALL  = 16'h3000;
    localparam logic [15:0] AOD_RISE = 16'h0054;
    localparam logic [15:0] AOD_FALL = 16'h00a8;
    localparam logic [15:0] G1_RISE  = 16'h000f;
    localparam logic [15:0] G1_FALL  = 16'h000f;
    localparam logic [15:0] G2_RISE  = 16'hf000;
    localparam logic [15:0] G2_FALL  = 16'h0000;
    localparam logic [15:0] G3_RISE  = 16'hebe0;
    localparam logic [15:0] G3_FALL  = 16'hc380;
    localparam logic [15:0] G3_EVENT = 16'h1000;
    localparam logic [15:0] NO_EVENT = 16'h0000;

endpackage

// >>> include/dism_flag_if.sv
// source, clear and status vectors of one sticky flag register
`timescale 1ns/1ps
interface dism_flag_if #(
    parameter int W = 16
);
    logic [W-1:0] src;
    logic [W-1:0] clr;
    logic [W-1:0] status;

    modport bank  (input src, input clr, output status);
    modport owner (output src, output clr, input status);
endinterface

// >>> verilog/dism_flag_bank.sv
// one register of sticky flags with per-bit edge or event capture
`timescale 1ns/1ps
module dism_flag_bank #(
    parameter int           W     = 16,
    parameter logic [W-1:0] RISE  = '0,
    parameter logic [W-1:0] FALL  = '0,
    parameter logic [W-1:0] EVENT = '0
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    dism_flag_if.bank bus
);
    logic [W-1:0] prev_src;
    wire  [W-1:0] rise_seen = bus.src & ~prev_src;
    wire  [W-1:0] fall_seen = ~bus.src & prev_src;
    wire  [W-1:0] set_now   = (rise_seen & RISE) | (fall_seen & FALL) | (bus.src & EVENT);
    // a new event in the clearing cycle survives the clear
    wire  [W-1:0] next_status = (bus.status & ~bus.clr) | set_now;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_src   <= '0;
            bus.status <= '0;
        end else if (i_ce) begin
            prev_src   <= bus.src;
            bus.status <= next_status;
        end
    end
endmodule

// >>> verilog/dism_irq_gate.sv
// masked reduction of a flag bank onto one registered interrupt line
`timescale 1ns/1ps
module dism_irq_gate #(
    parameter int N = 48
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [N-1:0] i_status,
    input  wire logic [N-1:0] i_mask,
    input  wire logic         i_out_mask,
    output logic              o_irq
);
    // mask bit 1 blocks its flag, output mask 1 blocks the whole line
    wire next_irq = (|(i_status & ~i_mask)) & ~i_out_mask;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= next_irq;
        end
    end
endmodule

// >>> testbench/dism_top_assertions.sv
// concurrent checks on dism_top ports
`timescale 1ns/1ps
module dism_top_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_irq1,
    input wire logic        o_irq2
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire take_rd = i_ce && i_reg_rd && !i_reg_wr;
    wire take_wr = i_ce && i_reg_wr && !i_reg_rd;
    wire in_m1   = (i_reg_addr - dism_pkg::OFF_IRQ1_MASK_BASE) < 16'h0006;
    wire in_m2   = (i_reg_addr - dism_pkg::OFF_IRQ2_MASK_BASE) < 16'h0006;
    wire in_aod  = i_reg_addr == dism_pkg::OFF_IRQ1_AOD_MASK;
    wire ctl1_wr = take_wr && i_reg_addr == dism_pkg::OFF_IRQ1_OUTPUT_CTRL && i_reg_wdata[0];
    wire ctl2_wr = take_wr && i_reg_addr == dism_pkg::OFF_IRQ2_OUTPUT_CTRL && i_reg_wdata[0];

    // the host leaves one idle cycle before a readback
    property readback(logic sel);
        take_wr && sel ##1 !i_reg_wr ##1 take_rd && i_reg_addr == $past(i_reg_addr, 2)
            |=> o_reg_rdata == $past(i_reg_wdata, 3);
    endproperty

    ////////////////////////////////////////////////////////////////////////////
    ce_freeze_a: assert property (!i_ce |=> $stable(o_irq1) && $stable(o_irq2))
        else $error("irq moved while frozen");
    rdata_hold_a: assert property (!(i_ce && i_reg_rd) |=> $stable(o_reg_rdata))
        else $error("rdata moved without read");
    out1_silence_a: assert property (ctl1_wr ##1 i_ce |=> !o_irq1)
        else $error("irq1 on while output masked");
    out2_silence_a: assert property (ctl2_wr ##1 i_ce |=> !o_irq2)
        else $error("irq2 on while output masked");
    ctrl1_width_a: assert property (take_rd && i_reg_addr == dism_pkg::OFF_IRQ1_OUTPUT_CTRL
        |=> o_reg_rdata[15:1] == 15'h0000) else $error("ctl1 extra bits");
    ctrl2_width_a: assert property (take_rd && i_reg_addr == dism_pkg::OFF_IRQ2_OUTPUT_CTRL
        |=> o_reg_rdata[15:1] == 15'h0000) else $error("ctl2 extra bits");
    mask1_rw_a: assert property (readback(in_m1))
        else $error("mask1 readback");
    mask2_rw_a: assert property (readback(in_m2))
        else $error("mask2 readback");
    aod_mask_a: assert property (readback(in_aod))
        else $error("aod mask readback");

    irq1_seen_c: cover property ($rose(o_irq1));
    irq2_seen_c: cover property ($rose(o_irq2));
    ctl_write_c: cover property (ctl1_wr ##1 i_ce);
endmodule

bind dism_top dism_top_checker u_checker (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_irq1(o_irq1), .o_irq2(o_irq2));

// >>> testbench/dism_host_model.sv
// host model: register port master
`timescale 1ns/1ps
module dism_host_model (
    input  wire logic        i_ref_clk,
    output logic      [15:0] o_reg_addr,
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic      [15:0] o_reg_wdata,
    input  wire logic [15:0] i_reg_rdata
);
    initial begin
        o_reg_addr  = 16'h0000;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    // released fields show the inverse
    task automatic write_reg(input logic [15:0] addr, data);
        @(posedge i_ref_clk);
        o_reg_addr  <= addr;
        o_reg_wdata <= data;
        o_reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~addr;
        o_reg_wdata <= ~data;
    endtask

    task automatic read_reg(input logic [15:0] addr, output logic [15:0] data);
        @(posedge i_ref_clk);
        o_reg_addr <= addr;
        o_reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~addr;
        #1 data = i_reg_rdata;
    endtask
endmodule

// >>> testbench/dism_top_tb.sv
// self-checking bench for dism_top
`timescale 1ns/1ps
module dism_top_tb;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        i_ce      = 1'b1;
    logic [25:0] src       = 26'h000_0000;
    logic [15:0] addr, wdata, rdata, got;
    logic        wr, rd, irq1, irq2;
    int          mismatches      = 0;
    int          samples_checked = 0;
    int          seed            = 81137;
    int          cycles          = 0;
    // per source: offset, rise bit, fall bit (ff: none)
    localparam logic [31:0] MAP [26] = '{32'h0d51_0405, 32'h0d51_0203, 32'h0d51_0607,
        32'h0d04_08ff, 32'h0d04_0000, 32'h0d05_0eff, 32'h0d05_0d0d, 32'h0d05_0c0c,
        32'h0d10_0000, 32'h0d10_0101, 32'h0d10_0202, 32'h0d10_0303, 32'h0d11_0fff,
        32'h0d11_0eff, 32'h0d11_0dff, 32'h0d11_0cff, 32'h0d12_0f0f, 32'h0d12_0e0e,
        32'h0d12_0dff, 32'h0d12_0cff, 32'h0d12_0bff, 32'h0d12_0909, 32'h0d12_0808,
        32'h0d12_0707, 32'h0d12_06ff, 32'h0d12_05ff};

    dism_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_gpin5(src[0]), .i_jack_detect(src[1]), .i_mic_clamp(src[2]), .i_boot_done(src[3]),
        .i_loop1_clock_good(src[4]), .i_speaker_shutdown(src[5]),
        .i_right_speaker_short(src[6]), .i_left_speaker_short(src[7]), .i_gpio(src[11:8]),
        .i_right_speaker_off_done(src[12]), .i_left_speaker_off_done(src[13]),
        .i_right_speaker_on_done(src[14]), .i_left_speaker_on_done(src[15]),
        .i_speaker_thermal_warning(src[16]), .i_speaker_thermal(src[17]),
        .i_headphone_sense_done(src[18]), .i_accessory_sense_event(src[19]),
        .i_write_sequencer_done(src[20]), .i_dynamics_signal(src[21]),
        .i_rate_converter_lock({src[22], src[23]}), .i_clock_too_slow(src[24]),
        .i_clock_too_fast(src[25]), .o_irq1(irq1), .o_irq2(irq2));
    dism_host_model host (.i_ref_clk(i_ref_clk), .o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_wdata(wdata), .i_reg_rdata(rdata));

    always #4 i_ref_clk = ~i_ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mask_reset(input int idx);
        return (idx == 4) ? 16'hfeff : 16'hffff;
    endfunction
    function automatic logic [15:0] bitv(input logic [7:0] b);
        return (b == 8'hff) ? 16'h0000 : 16'h0001 << b;
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [15:0] exp, seen);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, seen);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input string what, input logic [15:0] a, exp);
        host.read_reg(a, got);
        chk_word(what, exp, got);
    endtask

    // raise one unmasked flag, then gate it by output and flag mask
    task automatic irq_run(input int s, input logic [15:0] m_addr, m_val, c_addr, st,
                           input bit two);
        host.write_reg(m_addr, m_val);
        @(posedge i_ref_clk) src[s] <= ~src[s];
        repeat (2) @(posedge i_ref_clk);
        #1 chk_bit("irq unmasked flag", 1'b1, two ? irq2 : irq1);
        host.write_reg(c_addr, 16'h0001);
        @(posedge i_ref_clk) #1 chk_bit("irq output masked", 1'b0, two ? irq2 : irq1);
        host.write_reg(c_addr, 16'h0000);
        @(posedge i_ref_clk) #1 chk_bit("irq output open", 1'b1, two ? irq2 : irq1);
        host.write_reg(m_addr, 16'hffff);
        @(posedge i_ref_clk) #1 chk_bit("irq flag masked", 1'b0, two ? irq2 : irq1);
        host.write_reg(st, 16'hffff);
        chk_bit("other irq idle", 1'b0, two ? irq1 : irq2);
    endtask

    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        int          k;
        logic [15:0] a, v, er, ef;
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_chk("irq1 mask reset", 16'h0d08 + 16'(i), mask_reset(i));
            rd_chk("irq2 mask reset", 16'h0d18 + 16'(i), mask_reset(i));
        end
        rd_chk("aod mask reset", 16'h0d53, 16'hffff);
        rd_chk("ctl1 reset", 16'h0d0f, 16'h0000);
        rd_chk("ctl2 reset", 16'h0d1f, 16'h0000);
        host.write_reg(16'h0d06, 16'hffff);
        rd_chk("unmapped", 16'h0d06, 16'h0000);
        for (k = 0; k < 26; k++) begin
            a  = MAP[k][31:16];
            er = bitv(MAP[k][15:8]);
            ef = bitv(MAP[k][7:0]);
            @(posedge i_ref_clk) src[k] <= 1'b1;
            rd_chk("rise", a, er);
            chk_bit("irq1 boot", k == 3, irq1);
            chk_bit("irq2 masked", 1'b0, irq2);
            @(posedge i_ref_clk) src[k] <= 1'b0;
            rd_chk("fall", a, er | ef);
            host.write_reg(a, 16'h0000);
            rd_chk("zero write", a, er | ef);
            host.write_reg(a, 16'hffff);
            rd_chk("cleared", a, 16'h0000);
        end
        @(posedge i_ref_clk) i_ce <= 1'b0;
        @(posedge i_ref_clk) src[9] <= 1'b1;
        @(posedge i_ref_clk) src[9] <= 1'b0;
        @(posedge i_ref_clk) i_ce <= 1'b1;
        rd_chk("frozen pulse", 16'h0d10, 16'h0000);
        for (int n = 0; n < 40; n++) begin
            v = (n < 2) ? {16{n[0]}} : 16'($random(seed));
            k = $unsigned($random(seed)) % 13;
            a = (k == 12) ? 16'h0d53 : (((k < 6) ? 16'h0d08 : 16'h0d12) + 16'(k));
            host.write_reg(a, v);
            rd_chk("mask readback", a, v);
        end
        irq_run(0, 16'h0d53, 16'hffef, 16'h0d0f, 16'h0d51, 1'b0);
        irq_run(8, 16'h0d18, 16'hfffe, 16'h0d1f, 16'h0d10, 1'b1);
        close_out();
    end
endmodule
